/* common/pes_pkg.sv */
// Purpose: Shared constants and types for the PWM enable, sync and dead-time block
// Assumes: 100 MHz system clock, synchronous active-low reset
// Notes: Cycle counts derive from the printed times and rates
package pes_pkg;
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_REF_GOOD_NS = 20000;
    localparam int unsigned T_EN_OFF_NS = 2000;
    localparam int unsigned T_EN_MIN_NS = 3000;
    localparam int unsigned OSC_MIN_HZ = 50000;
    localparam int unsigned OSC_MAX_HZ = 1400000;
    localparam int unsigned SYNC_MIN_HZ = 84000;
    localparam int unsigned SYNC_MAX_HZ = 1890000;

    localparam int unsigned CNT_W = 16;
    // Least times round up, fixed delay is exact
    localparam logic [15:0] REF_GOOD_CYC =
        16'((T_REF_GOOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] EN_OFF_CYC = 16'(T_EN_OFF_NS / CLK_PERIOD_NS);
    localparam logic [15:0] EN_MIN_CYC =
        16'((T_EN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Oscillator periods in clock cycles
    localparam logic [15:0] OSC_PER_MAX = 16'(CLK_HZ / OSC_MIN_HZ);
    localparam logic [15:0] OSC_PER_MIN = 16'((CLK_HZ + OSC_MAX_HZ - 1) / OSC_MAX_HZ);
    localparam logic [15:0] SYNC_PER_MAX = 16'(CLK_HZ / SYNC_MIN_HZ);
    localparam logic [15:0] SYNC_PER_MIN = 16'((CLK_HZ + SYNC_MAX_HZ - 1) / SYNC_MAX_HZ);

    // Register port
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OSC_PERIOD = 8'h04;
    localparam logic [7:0] REG_DEAD_SP = 8'h08;
    localparam logic [7:0] REG_DEAD_PS = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int unsigned CTRL_SYNC_BIT = 0;
    localparam logic [15:0] RST_OSC_PERIOD = 16'h00c8;
    localparam logic [7:0] RST_DEAD = 8'h04;

    // Positions in the synchronised input vector
    localparam int unsigned IN_W = 8;
    localparam int unsigned IN_LOCKOUT = 0;
    localparam int unsigned IN_REF = 1;
    localparam int unsigned IN_HOT = 2;
    localparam int unsigned IN_OVP = 3;
    localparam int unsigned IN_EN = 4;
    localparam int unsigned IN_TSYNC = 5;
    localparam int unsigned IN_TRIP = 6;
    localparam int unsigned IN_SS = 7;

    typedef enum logic [3:0] {
        PES_ST_STANDBY = 4'h1,
        PES_ST_QUALIFY = 4'h2,
        PES_ST_READY = 4'h4,
        PES_ST_RUN = 4'h8
    } pes_state_e;

    typedef enum logic [3:0] {
        PES_SQ_IDLE = 4'h1,
        PES_SQ_SP = 4'h2,
        PES_SQ_ON = 4'h4,
        PES_SQ_PS = 4'h8
    } pes_seq_e;
endpackage

/* hw/pes_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels relative to CLK
// Notes: First stage feeds only the second stage
module pes_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

/* hw/pwm_enable_sync_deadtime.sv */
// Purpose: Start-up qualification, enable decoding, oscillator and dead-time sequencing
// Assumes: Comparator results arrive as asynchronous pin levels
// Notes: Outputs are registered from the next state, so they change in the same cycle as their state
module pwm_enable_sync_deadtime (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SUPPLY_LOCKOUT,
    input wire logic REF_GOOD,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic OVERVOLTAGE_SENSE,
    input wire logic ENABLE_IN,
    input wire logic TIMING_SYNC_INPUT,
    input wire logic PEAK_TRIP,
    input wire logic SOFTSTART_REACHED,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [31:0] RDATA,
    output logic PRIMARY_DRIVE_A,
    output logic PRIMARY_DRIVE_B,
    output logic RECTIFIER_DRIVE_A,
    output logic RECTIFIER_DRIVE_B,
    output logic SOFTSTART_CHARGE,
    output logic STANDBY
);
    logic [pes_pkg::IN_W-1:0] pins;
    logic [pes_pkg::IN_W-1:0] syn;

    assign pins = {SOFTSTART_REACHED, PEAK_TRIP, TIMING_SYNC_INPUT, ENABLE_IN,
                   OVERVOLTAGE_SENSE, THERMAL_SHUTDOWN, REF_GOOD, SUPPLY_LOCKOUT};

    pes_sync #(.WIDTH(pes_pkg::IN_W)) u_sync (
        .CLK(CLK),
        .RSTN(RSTN),
        .async_in(pins),
        .sync_out(syn)
    );

    wire lockout = syn[pes_pkg::IN_LOCKOUT];
    wire ref_good = syn[pes_pkg::IN_REF];
    wire hot = syn[pes_pkg::IN_HOT];
    wire overvoltage_sense = syn[pes_pkg::IN_OVP];
    wire en = syn[pes_pkg::IN_EN];
    wire tsync = syn[pes_pkg::IN_TSYNC];
    wire trip = syn[pes_pkg::IN_TRIP];
    wire ss_reached = syn[pes_pkg::IN_SS];

    // Registers
    logic sync_mode_ff;
    logic [15:0] period_ff;
    logic [7:0] sp_ff;
    logic [7:0] ps_ff;
    logic [31:0] rdata_ff;

    // Qualification and enable state
    pes_pkg::pes_state_e state_ff;
    pes_pkg::pes_state_e nxt_state;
    logic [15:0] ref_cnt_ff;
    logic [15:0] en_hi_cnt_ff;
    logic [15:0] en_lo_cnt_ff;
    logic en_d_ff;
    logic decided_ff;
    logic pulse_ff;

    // Oscillator and sequencer
    logic [15:0] osc_cnt_ff;
    logic tsync_d_ff;
    logic clamp_ff;
    pes_pkg::pes_seq_e seq_ff;
    pes_pkg::pes_seq_e nxt_seq;
    logic [7:0] dt_cnt_ff;
    logic pend_ff;
    logic side_ff;
    logic started_ff;

    logic prim_a_ff;
    logic prim_b_ff;
    logic rect_a_ff;
    logic rect_b_ff;
    logic ss_ff;
    logic standby_ff;

    // Start qualification
    wire ref_ok = ref_cnt_ff == pes_pkg::REF_GOOD_CYC;
    wire start_ok = !lockout && ref_ok && !hot && !overvoltage_sense;
    wire run = state_ff == pes_pkg::PES_ST_RUN;

    // Enable decoding; the noise filter trades 3 us of start latency for immunity
    wire en_valid = en && en_hi_cnt_ff == pes_pkg::EN_MIN_CYC - 16'h0001;
    wire en_fall = en_d_ff && !en;
    wire level_mode = decided_ff && !pulse_ff;
    wire level_off = level_mode && en_lo_cnt_ff == pes_pkg::EN_OFF_CYC - 16'h0001;
    wire pulse_off = decided_ff && pulse_ff && en_valid;
    wire disable_req = level_off || pulse_off;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pes_pkg::PES_ST_STANDBY: begin
                if (!lockout) begin
                    nxt_state = pes_pkg::PES_ST_QUALIFY;
                end
            end
            pes_pkg::PES_ST_QUALIFY: begin
                if (lockout) begin
                    nxt_state = pes_pkg::PES_ST_STANDBY;
                end else if (start_ok) begin
                    nxt_state = pes_pkg::PES_ST_READY;
                end
            end
            pes_pkg::PES_ST_READY: begin
                if (lockout) begin
                    nxt_state = pes_pkg::PES_ST_STANDBY;
                end else if (!start_ok) begin
                    nxt_state = pes_pkg::PES_ST_QUALIFY;
                end else if (en_valid) begin
                    nxt_state = pes_pkg::PES_ST_RUN;
                end
            end
            pes_pkg::PES_ST_RUN: begin
                if (lockout) begin
                    nxt_state = pes_pkg::PES_ST_STANDBY;
                end else if (!start_ok) begin
                    nxt_state = pes_pkg::PES_ST_QUALIFY;
                end else if (disable_req) begin
                    nxt_state = pes_pkg::PES_ST_READY;
                end
            end
            default: nxt_state = pes_pkg::PES_ST_STANDBY;
        endcase
    end

    wire nxt_run = nxt_state == pes_pkg::PES_ST_RUN;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_ff <= pes_pkg::PES_ST_STANDBY;
            en_d_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            en_d_ff <= en;
        end
    end

    // Reference must stay good without a break
    always_ff @(posedge CLK) begin
        if (!RSTN || lockout || !ref_good) begin
            ref_cnt_ff <= 16'h0000;
        end else if (!ref_ok) begin
            ref_cnt_ff <= ref_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN || !en) begin
            en_hi_cnt_ff <= 16'h0000;
        end else if (en_hi_cnt_ff != pes_pkg::EN_MIN_CYC) begin
            en_hi_cnt_ff <= en_hi_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN || en || !run) begin
            en_lo_cnt_ff <= 16'h0000;
        end else if (en_lo_cnt_ff != pes_pkg::EN_OFF_CYC) begin
            en_lo_cnt_ff <= en_lo_cnt_ff + 16'h0001;
        end
    end

    // Mode is fixed by the first fall of enable in a run
    always_ff @(posedge CLK) begin
        if (!RSTN || !run) begin
            decided_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else if (!decided_ff && en_fall) begin
            decided_ff <= 1'b1;
            pulse_ff <= !ss_reached;
        end
    end

    // Oscillator
    wire [15:0] per_eff = (period_ff < pes_pkg::OSC_PER_MIN) ? pes_pkg::OSC_PER_MIN :
                          (period_ff > pes_pkg::OSC_PER_MAX) ? pes_pkg::OSC_PER_MAX :
                          period_ff;
    wire sync_fall = tsync_d_ff && !tsync;
    // Edges faster than the sync range are ignored rather than shortening the cycle
    wire sync_edge = sync_fall && osc_cnt_ff >= pes_pkg::SYNC_PER_MIN - 16'h0001;
    wire sync_clamp = osc_cnt_ff >= pes_pkg::SYNC_PER_MAX - 16'h0001;
    wire free_end = osc_cnt_ff >= per_eff - 16'h0001;
    wire tick = sync_mode_ff ? (sync_edge || sync_clamp) : free_end;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            osc_cnt_ff <= 16'h0000;
            tsync_d_ff <= 1'b0;
            clamp_ff <= 1'b0;
        end else begin
            tsync_d_ff <= tsync;
            osc_cnt_ff <= tick ? 16'h0000 : osc_cnt_ff + 16'h0001;
            if (sync_mode_ff && sync_edge) begin
                clamp_ff <= 1'b0;
            end else if (sync_mode_ff && sync_clamp) begin
                clamp_ff <= 1'b1;
            end
        end
    end

    // Dead-time sequencer, one pulse per oscillator cycle
    wire seq_idle = seq_ff == pes_pkg::PES_SQ_IDLE;
    wire seq_start = run && seq_idle && (tick || pend_ff);
    wire sp_done = dt_cnt_ff == sp_ff - 8'h01;
    wire ps_done = dt_cnt_ff == ps_ff - 8'h01;
    wire prim_end = trip || tick;

    always_comb begin
        nxt_seq = seq_ff;
        case (seq_ff)
            pes_pkg::PES_SQ_IDLE: begin
                if (seq_start) begin
                    nxt_seq = (sp_ff == 8'h00) ? pes_pkg::PES_SQ_ON : pes_pkg::PES_SQ_SP;
                end
            end
            pes_pkg::PES_SQ_SP: begin
                if (sp_done) begin
                    nxt_seq = pes_pkg::PES_SQ_ON;
                end
            end
            pes_pkg::PES_SQ_ON: begin
                if (prim_end) begin
                    nxt_seq = (ps_ff == 8'h00) ? pes_pkg::PES_SQ_IDLE : pes_pkg::PES_SQ_PS;
                end
            end
            pes_pkg::PES_SQ_PS: begin
                if (ps_done) begin
                    nxt_seq = pes_pkg::PES_SQ_IDLE;
                end
            end
            default: nxt_seq = pes_pkg::PES_SQ_IDLE;
        endcase
        if (!nxt_run) begin
            nxt_seq = pes_pkg::PES_SQ_IDLE;
        end
    end

    wire nxt_side = seq_start ? !side_ff : side_ff;
    wire nxt_on = nxt_seq == pes_pkg::PES_SQ_ON;
    wire nxt_busy = nxt_seq != pes_pkg::PES_SQ_IDLE;
    wire nxt_started = nxt_run && (started_ff || nxt_on);
    // Rectifier is the complement of the opposite side's whole sequence, dead times included, so duty never drops below half
    wire nxt_rect_a = nxt_started && !(nxt_busy && nxt_side);
    wire nxt_rect_b = nxt_started && !(nxt_busy && !nxt_side);

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            seq_ff <= pes_pkg::PES_SQ_IDLE;
            dt_cnt_ff <= 8'h00;
            pend_ff <= 1'b0;
            side_ff <= 1'b1;
            started_ff <= 1'b0;
        end else begin
            seq_ff <= nxt_seq;
            dt_cnt_ff <= (nxt_seq != seq_ff) ? 8'h00 : dt_cnt_ff + 8'h01;
            // A tick during a busy sequence is held until the sequence ends
            pend_ff <= nxt_run && !seq_start && (pend_ff || tick);
            side_ff <= nxt_run ? nxt_side : 1'b1;
            started_ff <= nxt_started;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            prim_a_ff <= 1'b0;
            prim_b_ff <= 1'b0;
            rect_a_ff <= 1'b0;
            rect_b_ff <= 1'b0;
            ss_ff <= 1'b0;
            standby_ff <= 1'b1;
        end else begin
            prim_a_ff <= nxt_on && !nxt_side;
            prim_b_ff <= nxt_on && nxt_side;
            rect_a_ff <= nxt_rect_a;
            rect_b_ff <= nxt_rect_b;
            ss_ff <= nxt_run;
            standby_ff <= nxt_state == pes_pkg::PES_ST_STANDBY;
        end
    end

    // Register port
    wire [31:0] status_w = {23'h000000, ref_ok, ss_ff, clamp_ff, decided_ff, pulse_ff,
                            state_ff};
    wire [31:0] rd_mux = (ADDR == pes_pkg::REG_CTRL) ? {31'h00000000, sync_mode_ff} :
                         (ADDR == pes_pkg::REG_OSC_PERIOD) ? {16'h0000, period_ff} :
                         (ADDR == pes_pkg::REG_DEAD_SP) ? {24'h000000, sp_ff} :
                         (ADDR == pes_pkg::REG_DEAD_PS) ? {24'h000000, ps_ff} :
                         (ADDR == pes_pkg::REG_STATUS) ? status_w : 32'h00000000;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sync_mode_ff <= 1'b0;
            period_ff <= pes_pkg::RST_OSC_PERIOD;
            sp_ff <= pes_pkg::RST_DEAD;
            ps_ff <= pes_pkg::RST_DEAD;
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= RD_EN ? rd_mux : 32'h00000000;
            if (WR_EN && ADDR == pes_pkg::REG_CTRL) begin
                sync_mode_ff <= WDATA[pes_pkg::CTRL_SYNC_BIT];
            end
            if (WR_EN && ADDR == pes_pkg::REG_OSC_PERIOD) begin
                period_ff <= WDATA[15:0];
            end
            if (WR_EN && ADDR == pes_pkg::REG_DEAD_SP) begin
                sp_ff <= WDATA[7:0];
            end
            if (WR_EN && ADDR == pes_pkg::REG_DEAD_PS) begin
                ps_ff <= WDATA[7:0];
            end
        end
    end

    assign RDATA = rdata_ff;
    assign PRIMARY_DRIVE_A = prim_a_ff;
    assign PRIMARY_DRIVE_B = prim_b_ff;
    assign RECTIFIER_DRIVE_A = rect_a_ff;
    assign RECTIFIER_DRIVE_B = rect_b_ff;
    assign SOFTSTART_CHARGE = ss_ff;
    assign STANDBY = standby_ff;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    a_prim_exclusive: assert property (!(prim_a_ff && prim_b_ff))
        else $error("both primaries on");
    a_standby_quiet: assert property (
        state_ff == pes_pkg::PES_ST_STANDBY |->
        !(prim_a_ff || prim_b_ff || rect_a_ff || rect_b_ff || ss_ff))
        else $error("drive active in stand-by");
    a_start_cause: assert property (
        (run && !$past(run)) |-> $past(start_ok) && $past(en_valid))
        else $error("run entered without qualification");
    a_ss_follows_run: assert property ($rose(run) |=> ss_ff && SOFTSTART_CHARGE)
        else $error("soft-start source not on");
    a_level_disable: assert property (
        (run && level_off && start_ok) |=> state_ff == pes_pkg::PES_ST_READY)
        else $error("level enable did not disable");
    a_pulse_disable: assert property (
        (run && pulse_off && start_ok) |=> state_ff == pes_pkg::PES_ST_READY)
        else $error("pulse enable did not disable");
    a_mode_decide: assert property (
        (run && nxt_run && !decided_ff && en_fall) |=>
        decided_ff && (pulse_ff == !$past(ss_reached)))
        else $error("enable mode wrong");
    a_sp_zero_edge: assert property (
        (seq_start && sp_ff == 8'h00 && nxt_run) |=> seq_ff == pes_pkg::PES_SQ_ON)
        else $error("zero dead time not coincident");
    a_ps_hold: assert property (
        seq_ff == pes_pkg::PES_SQ_PS |-> !prim_a_ff && !prim_b_ff &&
        (side_ff ? !rect_a_ff : !rect_b_ff))
        else $error("rectifier on during primary-off dead time");
    a_sync_clamp: assert property ((sync_mode_ff && sync_clamp) |=> osc_cnt_ff == 16'h0000)
        else $error("sync clamp missed");
    a_osc_bound: assert property (osc_cnt_ff < pes_pkg::OSC_PER_MAX)
        else $error("oscillator period too long");
    a_side_alt: assert property ((seq_start && nxt_run) |=> side_ff != $past(side_ff))
        else $error("phase did not alternate");
    a_trip_off: assert property (
        (seq_ff == pes_pkg::PES_SQ_ON && trip && nxt_run) |=> seq_ff != pes_pkg::PES_SQ_ON)
        else $error("primary not ended by trip");

    c_pulse_run: cover property (run && decided_ff && pulse_ff);
    c_level_off: cover property (run && level_off);
    c_sync_clamp: cover property (sync_mode_ff && sync_clamp);
    c_prim_b_on: cover property ($rose(prim_b_ff));
endmodule

/* bench/pes_gate_drv.sv */
// Purpose: Gate driver model standing on the four drive outputs
// Assumes: Drives active high, settled at the falling CLK edge
// Notes: Counts cross-conduction so the bench decides the verdict
module pes_gate_drv (
    input wire logic clk,
    input wire logic prim_a,
    input wire logic prim_b,
    input wire logic rect_a,
    input wire logic rect_b,
    output int overlap_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic shoot;
    int cnt = 0;
    // A primary against the other primary or the opposite rectifier shorts the bridge
    assign shoot = (prim_a & prim_b) | (prim_a & rect_b) | (prim_b & rect_a);
    assign overlap_cnt = cnt;
    always @(negedge clk) begin
        if (shoot === 1'b1) begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* bench/tb.sv */
// Purpose: Self-checking bench for start-up, enable decoding, sync and dead times
// Assumes: Register port with one-cycle read data, 100 MHz clock
// Notes: Edge times are recorded at the falling edge, where outputs are settled
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, lockout = 1'b0, ref_ok = 1'b0, hot = 1'b0, overvoltage_sense = 1'b0;
    logic en = 1'b0, tsync = 1'b0, trip = 1'b0, ss_hi = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic sync_on = 1'b0, pa_q = 1'b0, rb_q = 1'b0, ts_q = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_v;
    logic prim_a, prim_b, rect_a, rect_b, charge, standby;
    logic [3:0] drv;
    int err_count = 0, comparisons = 0, cyc = 0, overlap_cnt;
    int t_par = 0, t_par_prev = 0, t_rbf = 0, t_paf = 0, t_rbr = 0, t_sf = 0;
    logic [7:0] adr_tab [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
    logic [31:0] rst_tab [5] = '{32'h0, 32'(pes_pkg::RST_OSC_PERIOD),
        32'(pes_pkg::RST_DEAD), 32'(pes_pkg::RST_DEAD), 32'h0};
    assign drv = {prim_a, prim_b, rect_a, rect_b};

    pwm_enable_sync_deadtime DUT (.CLK(clk), .RSTN(rstn), .SUPPLY_LOCKOUT(lockout),
        .REF_GOOD(ref_ok), .THERMAL_SHUTDOWN(hot), .OVERVOLTAGE_SENSE(overvoltage_sense), .ENABLE_IN(en),
        .TIMING_SYNC_INPUT(tsync), .PEAK_TRIP(trip), .SOFTSTART_REACHED(ss_hi), .ADDR(addr),
        .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata), .PRIMARY_DRIVE_A(prim_a),
        .PRIMARY_DRIVE_B(prim_b), .RECTIFIER_DRIVE_A(rect_a), .RECTIFIER_DRIVE_B(rect_b),
        .SOFTSTART_CHARGE(charge), .STANDBY(standby));
    pes_gate_drv drivers (.clk(clk), .prim_a(prim_a), .prim_b(prim_b), .rect_a(rect_a),
        .rect_b(rect_b), .overlap_cnt(overlap_cnt));

    initial begin
        forever #5 clk = ~clk;
    end
    // Sync source falls every 300 cycles; held still when switched off
    initial begin
        forever begin
            repeat (150) @(posedge clk);
            if (sync_on) begin
                tsync <= ~tsync;
            end
        end
    end
    always @(negedge clk) begin
        cyc <= cyc + 1;
        pa_q <= prim_a;
        rb_q <= rect_b;
        ts_q <= tsync;
        if (prim_a === 1'b1 && pa_q === 1'b0) begin
            t_par <= cyc;
            t_par_prev <= t_par;
        end
        if (prim_a === 1'b0 && pa_q === 1'b1) begin
            t_paf <= cyc;
        end
        if (rect_b === 1'b0 && rb_q === 1'b1) begin
            t_rbf <= cyc;
        end
        if (rect_b === 1'b1 && rb_q === 1'b0) begin
            t_rbr <= cyc;
        end
        if (tsync === 1'b0 && ts_q === 1'b1) begin
            t_sf <= cyc;
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Strobes rise one edge after the call starts, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic pulse(input int n);
        @(posedge clk);
        en <= 1'b1;
        repeat (n) @(posedge clk);
        en <= 1'b0;
    endtask
    task automatic wait_for(input bit on_charge, input int lim);
        int i;
        i = 0;
        while ((on_charge ? charge : prim_a) !== 1'b1 && i < lim) begin
            step(1);
            i++;
        end
        if (i >= lim) begin
            err_count++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            report_and_stop();
        end
        step(1);
    endtask

    initial begin
        step(20);
        check({31'h0, standby}, 32'h1, "standby in reset");
        check({28'h0, drv}, 32'h0, "drives in reset");
        @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(adr_tab[i], rd_v);
            check(rd_v, rst_tab[i], "reset value");
        end
        wr(8'h14, 32'hffff_ffff);
        rd(8'h00, rd_v);
        check(rd_v, 32'h0, "unmapped write leaks");
        pulse(400);
        step(20);
        check({31'h0, charge}, 32'h0, "start without reference");
        ref_ok <= 1'b1;
        step(2100);
        rd(pes_pkg::REG_STATUS, rd_v);
        check({31'h0, rd_v[8]}, 32'h1, "reference qualified");
        hot <= 1'b1;
        pulse(400);
        step(20);
        check({31'h0, charge}, 32'h0, "start while hot");
        hot <= 1'b0;
        overvoltage_sense <= 1'b1;
        pulse(400);
        step(20);
        check({31'h0, charge}, 32'h0, "start in overvoltage");
        overvoltage_sense <= 1'b0;
        pulse(250);
        step(20);
        check({31'h0, charge}, 32'h0, "short pulse started");
        $display("start qualification done");
        wr(pes_pkg::REG_DEAD_SP, 32'h2);
        wr(pes_pkg::REG_DEAD_PS, 32'h3);
        ss_hi <= 1'b1;
        @(posedge clk);
        en <= 1'b1;
        step(295);
        check({31'h0, charge}, 32'h0, "started before minimum width");
        wait_for(1'b1, 30);
        step(1300);
        wait_for(1'b0, 500);
        check(32'(overlap_cnt), 32'h0, "cross-conduction");
        check(32'(t_par - t_par_prev), 32'd400, "output period");
        check(32'(t_par - t_rbf), 32'd2, "rectifier-off to primary-on");
        check(32'(t_rbr - t_paf), 32'd3, "primary-off to rectifier-on");
        step(50);
        trip <= 1'b1;
        step(6);
        check({31'h0, prim_a}, 32'h0, "primary kept on after trip");
        trip <= 1'b0;
        @(posedge clk);
        en <= 1'b0;
        step(100);
        rd(pes_pkg::REG_STATUS, rd_v);
        check({30'h0, rd_v[5:4]}, 32'h2, "level mode decided");
        step(96);
        check({31'h0, charge}, 32'h1, "disabled too early");
        step(10);
        check({27'h0, charge, drv}, 32'h0, "still running after delay");
        $display("level enable done");
        ss_hi <= 1'b0;
        pulse(400);
        step(600);
        check({31'h0, charge}, 32'h1, "pulse fall disabled");
        rd(pes_pkg::REG_STATUS, rd_v);
        check({31'h0, rd_v[4]}, 32'h1, "pulse mode flag");
        pulse(400);
        step(10);
        check({31'h0, charge}, 32'h0, "second pulse left it on");
        $display("pulse enable done");
        wr(pes_pkg::REG_CTRL, 32'h1);
        ss_hi <= 1'b1;
        sync_on <= 1'b1;
        @(posedge clk);
        en <= 1'b1;
        wait_for(1'b1, 400);
        step(2000);
        wait_for(1'b0, 700);
        check(32'(t_par - t_par_prev), 32'd600, "locked period");
        check({31'h0, t_par - t_sf >= 2 && t_par - t_sf <= 16}, 32'h1, "sync alignment");
        sync_on <= 1'b0;
        step(5000);
        wait_for(1'b0, 2500);
        check(32'(t_par - t_par_prev), 32'd2380, "clamped period");
        rd(pes_pkg::REG_STATUS, rd_v);
        check({31'h0, rd_v[6]}, 32'h1, "clamp flag");
        $display("sync done");
        wr(pes_pkg::REG_CTRL, 32'h0);
        wr(pes_pkg::REG_OSC_PERIOD, 32'd10);
        wr(pes_pkg::REG_DEAD_SP, 32'h0);
        step(1000);
        wait_for(1'b0, 300);
        check(32'(t_par - t_par_prev), 32'd144, "period clamped to range");
        check(32'(t_par - t_rbf), 32'd0, "zero dead time edges");
        check(32'(overlap_cnt), 32'h0, "cross-conduction");
        lockout <= 1'b1;
        step(8);
        check({27'h0, standby, drv}, 32'h10, "lockout stand-by");
        $display("free run and lockout done");
        report_and_stop();
    end
endmodule
